//--- design/sac_pkg.sv
// Package with constants, types and timing for the converter control block
//******************************************************************************
//******************************************************************************
package sac_pkg;
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned RES_W          = 14;
	localparam int unsigned FIFO_DEPTH     = 8;
	localparam logic [13:0] MARKER_CODE    = 14'h3F80;
	localparam logic [13:0] ZERO_CODE      = 14'h0000;
	localparam int unsigned FOLD_BITS      = 6;
	localparam int unsigned INIT_CONVS     = 4;
	// Conversion time and reset abort bound, nanoseconds
	localparam int unsigned CONV_NS        = 273;
	localparam int unsigned ABORT_NS       = 45;
	localparam int unsigned CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ABORT_CYC      = (ABORT_NS * CLK_MHZ) / 1000;
	// Reset phase length before powerdown, nanoseconds
	localparam int unsigned RST_PHASE_NS   = 1000;
	localparam int unsigned RST_PHASE_CYC  = (RST_PHASE_NS * CLK_MHZ) / 1000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_NAP,
		ST_RESET,
		ST_POWERDOWN
	} sac_state_e;

	// One finished result with its validity
	typedef struct packed {
		logic        valid_init;
		logic        aborted;
		logic [13:0] code;
	} sac_result_s;
endpackage

//--- design/sac_fifo.sv
// Result FIFO with valid and ready on both sides
module sac_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("sac_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// Pointer update
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule

//--- design/sac_ctrl.sv
// Top of the converter control and parallel readout block
module sac_ctrl #(
	parameter int unsigned RST_PHASE_CYCLES = sac_pkg::RST_PHASE_CYC,
	parameter int unsigned CONV_CYCLES      = sac_pkg::CONV_CYC
) (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// Host strobes, synchronous to the clock
	input  wire logic        CHIP_SELECT_N,
	input  wire logic        READ_N,
	input  wire logic        SAMPLE_CONVERT_N,
	input  wire logic        BYTE_FOLD,
	input  wire logic        NAP_ENABLE_N,
	input  wire logic        POWERDOWN_RESET_N,
	// Result from the SAR core
	input  wire logic [13:0] CORE_CODE,
	// Result bus, three signals per pin
	input  wire logic [13:0] RESULT_BUS_IN,
	output logic      [13:0] RESULT_BUS_OUT,
	output logic      [13:0] RESULT_BUS_OE,
	// Status
	output logic             BUSY,
	output logic             SAMPLING,
	output logic             NAPPING,
	output logic             POWERED_DOWN,
	output logic             RESULT_VALID,
	// Result stream
	output logic             STREAM_VALID,
	input  wire logic        STREAM_READY,
	output logic      [15:0] STREAM_DATA
);
	initial begin
		if (CONV_CYCLES < 2 || RST_PHASE_CYCLES < 2)
			$error("sac_ctrl counts must be at least 2");
		if (CONV_CYCLES - 1 > sac_pkg::ABORT_CYC + CONV_CYCLES)
			$error("sac_ctrl abort bound not served");
	end

	//**************************************************************************
	// Edge detection
	//**************************************************************************
	logic cs_n_q;
	logic cv_n_q;
	logic pr_n_q;
	wire  cs_fall = cs_n_q && !CHIP_SELECT_N;
	wire  cv_rise = !cv_n_q && SAMPLE_CONVERT_N;
	wire  cv_fall = cv_n_q && !SAMPLE_CONVERT_N;

	// Previous strobe levels
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cs_n_q <= 1'b1;
			cv_n_q <= 1'b0;
			pr_n_q <= 1'b1;
		end else begin
			cs_n_q <= CHIP_SELECT_N;
			cv_n_q <= SAMPLE_CONVERT_N;
			pr_n_q <= POWERDOWN_RESET_N;
		end
	end

	//**************************************************************************
	// Sequencing
	//**************************************************************************
	sac_pkg::sac_state_e st_q;
	sac_pkg::sac_state_e st_d;
	logic [31:0]         cnt_q;
	logic [31:0]         cnt_d;
	logic [2:0]          init_q;
	logic [13:0]         res_q;
	logic [13:0]         res_d;
	logic                res_ok_q;
	logic                res_ok_d;
	logic                done_pulse;
	logic                abort_pulse;

	// Start conditions for sampling and conversion
	wire samp_by_cv  = cv_rise && !CHIP_SELECT_N;
	wire samp_by_cs  = cs_fall && SAMPLE_CONVERT_N;
	wire conv_start  = (cv_fall && !CHIP_SELECT_N)
	                 || (cs_fall && !SAMPLE_CONVERT_N);
	wire conv_end    = (st_q == sac_pkg::ST_CONVERT) && (cnt_q == 32'(CONV_CYCLES - 1));
	wire abort_req   = (st_q == sac_pkg::ST_CONVERT) && cs_fall && SAMPLE_CONVERT_N;
	// Overlapped start: select low and convert high at the internal end
	wire back_to_back = conv_end && !CHIP_SELECT_N && SAMPLE_CONVERT_N;
	wire init_done   = (init_q == 3'(sac_pkg::INIT_CONVS));

	// Next state logic
	always_comb begin
		st_d        = st_q;
		cnt_d       = cnt_q + 32'h1;
		res_d       = res_q;
		res_ok_d    = res_ok_q;
		done_pulse  = 1'b0;
		abort_pulse = 1'b0;
		case (st_q)
			sac_pkg::ST_IDLE, sac_pkg::ST_NAP: begin
				// Nap while enabled and idle; leave as soon as sampling starts
				if (samp_by_cv || samp_by_cs)
					st_d = sac_pkg::ST_SAMPLE;
				else if (!NAP_ENABLE_N)
					st_d = sac_pkg::ST_NAP;
				else
					st_d = sac_pkg::ST_IDLE;
				if (conv_start) begin
					st_d  = sac_pkg::ST_CONVERT;
					cnt_d = 32'h0;
				end
			end
			sac_pkg::ST_SAMPLE: begin
				if (conv_start) begin
					st_d  = sac_pkg::ST_CONVERT;
					cnt_d = 32'h0;
				end
			end
			sac_pkg::ST_CONVERT: begin
				if (abort_req) begin
					// Marker replaces the result and stays until a later conversion
					res_d       = sac_pkg::MARKER_CODE;
					res_ok_d    = 1'b0;
					abort_pulse = 1'b1;
					st_d        = sac_pkg::ST_SAMPLE;
				end else if (conv_end) begin
					res_d      = CORE_CODE;
					res_ok_d   = init_done;
					done_pulse = 1'b1;
					if (back_to_back)
						st_d = sac_pkg::ST_SAMPLE;
					else if (!NAP_ENABLE_N)
						st_d = sac_pkg::ST_NAP;
					else
						st_d = sac_pkg::ST_IDLE;
				end
			end
			sac_pkg::ST_RESET: begin
				res_d    = sac_pkg::MARKER_CODE;
				res_ok_d = 1'b0;
				if (POWERDOWN_RESET_N)
					st_d = sac_pkg::ST_IDLE;
				else if (cnt_q >= 32'(RST_PHASE_CYCLES - 1))
					st_d = sac_pkg::ST_POWERDOWN;
			end
			sac_pkg::ST_POWERDOWN: begin
				if (POWERDOWN_RESET_N)
					st_d = sac_pkg::ST_IDLE;
			end
			default: st_d = sac_pkg::ST_IDLE;
		endcase
		// Reset pin falling overrides state, count and result, aborting at once
		if (!POWERDOWN_RESET_N && pr_n_q) begin
			st_d  = sac_pkg::ST_RESET;
			cnt_d = 32'h0;
			res_d = sac_pkg::MARKER_CODE;
			res_ok_d = 1'b0;
		end
	end

	// State, counter and result registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_q     <= sac_pkg::ST_IDLE;
			cnt_q    <= 32'h0;
			res_q    <= sac_pkg::ZERO_CODE;
			res_ok_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			res_q    <= res_d;
			res_ok_q <= res_ok_d;
		end
	end

	// Count conversions since reset; saturates once initialised
	always_ff @(posedge SYS_CLK) begin
		if (RST || st_q == sac_pkg::ST_RESET || st_q == sac_pkg::ST_POWERDOWN)
			init_q <= 3'h0;
		else if (done_pulse && !init_done)
			init_q <= init_q + 3'h1;
	end

	//**************************************************************************
	// Readout
	//**************************************************************************
	// Fold the low six bits to the top when requested
	wire [13:0] folded   = {res_q[sac_pkg::FOLD_BITS-1:0], 8'h00};
	wire [13:0] bus_word = BYTE_FOLD ? folded : res_q;
	wire        drive    = !CHIP_SELECT_N && !READ_N;

	// Bus and status outputs, all registered
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RESULT_BUS_OUT <= 14'h0000;
			RESULT_BUS_OE  <= 14'h0000;
			BUSY           <= 1'b0;
			SAMPLING       <= 1'b0;
			NAPPING        <= 1'b0;
			POWERED_DOWN   <= 1'b0;
			RESULT_VALID   <= 1'b0;
		end else begin
			RESULT_BUS_OUT <= bus_word;
			RESULT_BUS_OE  <= {14{drive}};
			BUSY           <= (st_d == sac_pkg::ST_CONVERT);
			SAMPLING       <= (st_d == sac_pkg::ST_SAMPLE);
			NAPPING        <= (st_d == sac_pkg::ST_NAP);
			POWERED_DOWN   <= (st_d == sac_pkg::ST_POWERDOWN);
			RESULT_VALID   <= res_ok_d;
		end
	end

	//**************************************************************************
	// Result stream through the FIFO
	//**************************************************************************
	sac_pkg::sac_result_s push_word;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic [15:0]          fifo_out_data;
	logic                 out_take;

	assign push_word = '{valid_init: init_done, aborted: abort_pulse,
	                     code: abort_pulse ? sac_pkg::MARKER_CODE : CORE_CODE};
	assign out_take  = fifo_out_valid && (!STREAM_VALID || STREAM_READY);

	sac_fifo #(
		.WIDTH (16),
		.DEPTH (sac_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (done_pulse || abort_pulse),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (out_take),
		.out_data  (fifo_out_data)
	);

	// Output stage register; a full FIFO drops results, never stalls conversion
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			STREAM_VALID <= 1'b0;
			STREAM_DATA  <= 16'h0000;
		end else if (out_take) begin
			STREAM_VALID <= 1'b1;
			STREAM_DATA  <= fifo_out_data;
		end else if (STREAM_READY) begin
			STREAM_VALID <= 1'b0;
		end
	end

	//**************************************************************************
	// Checks
	//**************************************************************************
	bus_enable_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(CHIP_SELECT_N || READ_N) |=> (RESULT_BUS_OE == 14'h0000))
		else $error("bus driven while select or read high");
	bus_fold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		BYTE_FOLD |=> (RESULT_BUS_OUT[7:0] == 8'h00))
		else $error("folded bus low bits not zero");
	busy_rise_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(conv_start && POWERDOWN_RESET_N && pr_n_q &&
		 (st_q == sac_pkg::ST_SAMPLE)) |=> BUSY)
		else $error("busy not raised after conversion start");
	busy_len_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(BUSY) |-> BUSY [*2])
		else $error("busy too short");
	abort_code_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		abort_req |=> (res_q == sac_pkg::MARKER_CODE))
		else $error("abort did not load marker");
	reset_abort_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(!POWERDOWN_RESET_N && pr_n_q) |=> (!BUSY && res_q == sac_pkg::MARKER_CODE))
		else $error("reset did not abort");
	sample_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st_q == sac_pkg::ST_IDLE && samp_by_cv && !conv_start && pr_n_q
		 && POWERDOWN_RESET_N) |=> SAMPLING)
		else $error("sampling not started");
	nap_exit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(NAPPING && NAP_ENABLE_N && !samp_by_cv && !samp_by_cs && !conv_start
		 && POWERDOWN_RESET_N && pr_n_q) |=> !NAPPING)
		else $error("nap held after enable released");

	//**************************************************************************
	// Further checks on timing, codes and the stream
	//**************************************************************************
	// Reset pin falling in this cycle
	wire         pin_fall = !POWERDOWN_RESET_N && pr_n_q;
	logic [31:0] busy_run_q;

	// Count consecutive busy cycles; a stuck converter would otherwise go unseen
	always_ff @(posedge SYS_CLK) begin
		if (RST || !BUSY)
			busy_run_q <= 32'h0;
		else
			busy_run_q <= busy_run_q + 32'h1;
	end

	// Busy length and end of conversion
	busy_bound_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		busy_run_q <= 32'(CONV_CYCLES))
		else $error("busy held past the conversion time");
	busy_fall_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		conv_end |=> !BUSY)
		else $error("busy not lowered at conversion end");
	result_load_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(conv_end && !abort_req && !pin_fall) |=> (res_q == $past(CORE_CODE)))
		else $error("finished result not loaded");

	// Start paths and nap entry
	cs_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st_q == sac_pkg::ST_IDLE && samp_by_cs && !conv_start && !pin_fall
		 && POWERDOWN_RESET_N) |=> SAMPLING)
		else $error("select fall did not start sampling");
	overlap_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(back_to_back && !abort_req && POWERDOWN_RESET_N) |=> SAMPLING)
		else $error("overlapped sampling not started");
	nap_enter_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(conv_end && !abort_req && !back_to_back && !NAP_ENABLE_N
		 && POWERDOWN_RESET_N) |=> NAPPING)
		else $error("nap not entered after conversion");

	// Reset phase, powerdown and wake
	reset_marker_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st_q == sac_pkg::ST_RESET) |=> (res_q == sac_pkg::MARKER_CODE))
		else $error("marker not shown in reset phase");
	powerdown_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st_q == sac_pkg::ST_RESET && !POWERDOWN_RESET_N
		 && cnt_q >= 32'(RST_PHASE_CYCLES - 1)) |=> POWERED_DOWN)
		else $error("long reset did not power down");
	wake_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(POWERED_DOWN && POWERDOWN_RESET_N) |=> !POWERED_DOWN)
		else $error("powerdown held after pin release");

	// Result validity and marker retention
	init_invalid_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(done_pulse && !init_done) |=> !RESULT_VALID)
		else $error("early result flagged valid");
	marker_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(res_q == sac_pkg::MARKER_CODE && !done_pulse && !pin_fall)
		|=> (res_q == sac_pkg::MARKER_CODE))
		else $error("marker lost before a conversion ended");

	// Bus word and enable
	bus_drive_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(!CHIP_SELECT_N && !READ_N) |=> (RESULT_BUS_OE == 14'h3FFF))
		else $error("bus not driven during read");
	fold_top_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		BYTE_FOLD |=> (RESULT_BUS_OUT[13:8] == $past(res_q[5:0])))
		else $error("folded bits not on top");
	unfold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!BYTE_FOLD |=> (RESULT_BUS_OUT == $past(res_q)))
		else $error("full word not on bus");

	// Stream output holds while the sink stalls
	stream_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(STREAM_VALID && !STREAM_READY) |=> (STREAM_VALID && $stable(STREAM_DATA)))
		else $error("stream word changed while stalled");
endmodule

//--- testbench/sac_host.sv
// Host side model: sees the three-state result bus as wire levels
module sac_host (
	// Clock
	input  wire logic        clk,
	// Pins from the block
	input  wire logic [13:0] bus_out,
	input  wire logic [13:0] bus_oe,
	// Level the host sees
	output logic      [13:0] bus_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] last_q = 14'h0000;
	// Released pins show the inverse of the last level, so stale data never passes
	assign bus_seen = (bus_oe & bus_out) | (~bus_oe & ~last_q);
	// Remember the last driven level of each pin
	always_ff @(posedge clk) begin
		last_q <= (bus_oe & bus_out) | (~bus_oe & last_q);
	end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the converter control and readout block
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CONV = 12;
	localparam int PH = 20;
	logic clk = 0, rst = 1, cs_n = 1, rd_n = 1, cv_n = 0, fold = 0;
	logic nap_n = 1, pr_n = 1, rdy = 1;
	logic [13:0] core = 14'h0000;
	logic [13:0] bus_o, bus_oe, bus, v;
	logic busy, smp, nap, pd, rv, sv;
	logic [15:0] sd;
	int bad_count = 0, cmp_count = 0, cyc = 0, n;
	sac_ctrl #(.RST_PHASE_CYCLES(PH), .CONV_CYCLES(CONV)) sac_ctrl_i (
		.SYS_CLK(clk), .RST(rst), .CHIP_SELECT_N(cs_n), .READ_N(rd_n),
		.SAMPLE_CONVERT_N(cv_n), .BYTE_FOLD(fold), .NAP_ENABLE_N(nap_n),
		.POWERDOWN_RESET_N(pr_n), .CORE_CODE(core), .RESULT_BUS_IN(bus),
		.RESULT_BUS_OUT(bus_o), .RESULT_BUS_OE(bus_oe), .BUSY(busy),
		.SAMPLING(smp), .NAPPING(nap), .POWERED_DOWN(pd), .RESULT_VALID(rv),
		.STREAM_VALID(sv), .STREAM_READY(rdy), .STREAM_DATA(sd));
	sac_host sac_host_i (.clk(clk), .bus_out(bus_o), .bus_oe(bus_oe), .bus_seen(bus));
	// Clock at 200 MHz
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Wait for the end of a conversion, bounded, counting busy cycles
	task automatic wbusy(output int m);
		m = 0;
		while (busy === 1'b1 && m < 4 * CONV) begin
			tick(1);
			m++;
		end
	endtask
	// Full conversion started by the convert input with select low
	task automatic conv(input logic [13:0] c, output int m);
		int k;
		k = 0;
		core = c;
		cs_n = 0;
		cv_n = 1;
		tick(2);
		`CHK(smp, 1'b1)
		cv_n = 0;
		while (busy !== 1'b1 && k < 5) begin
			tick(1);
			k++;
		end
		wbusy(m);
	endtask
	// Read with select and read strobe low; no read near a convert fall
	task automatic rd(input logic f, output logic [13:0] d);
		fold = f;
		cs_n = 0;
		rd_n = 0;
		tick(2);
		`CHK(bus_oe, 14'h3FFF)
		d = bus;
		rd_n = 1;
		tick(2);
		`CHK(bus_oe, 14'h0000)
		fold = 0;
	endtask
	task automatic t_basic;
		conv(14'h2A5B, n);
		`CHK(n, CONV)
		rd(0, v);
		`CHK(v, 14'h2A5B)
		rd(1, v);
		`CHK(v, 14'h1B00)
		$display("test basic done");
	endtask
	task automatic t_cs;
		core = 14'h1234;
		cs_n = 1;
		cv_n = 1;
		tick(2);
		cs_n = 0;
		tick(2);
		`CHK(smp, 1'b1)
		cs_n = 1;
		cv_n = 0;
		tick(2);
		cs_n = 0;
		tick(2);
		`CHK(busy, 1'b1)
		wbusy(n);
		rd(0, v);
		`CHK(v, 14'h1234)
		$display("test select start done");
	endtask
	task automatic t_abort;
		core = 14'h0555;
		cs_n = 0;
		cv_n = 1;
		tick(2);
		cv_n = 0;
		tick(2);
		`CHK(busy, 1'b1)
		cv_n = 1;
		cs_n = 1;
		tick(1);
		cs_n = 0;
		tick(2);
		`CHK(busy, 1'b0)
		rd(0, v);
		`CHK(v, sac_pkg::MARKER_CODE)
		tick(CONV);
		rd(0, v);
		`CHK(v, sac_pkg::MARKER_CODE)
		$display("test abort done");
	endtask
	task automatic t_b2b;
		core = 14'h0ABC;
		cs_n = 0;
		cv_n = 1;
		tick(2);
		cv_n = 0;
		tick(3);
		// High pulse spans the rest of the conversion
		cv_n = 1;
		wbusy(n);
		`CHK(smp, 1'b1)
		rd(0, v);
		`CHK(v, 14'h0ABC)
		cv_n = 0;
		tick(2);
		wbusy(n);
		$display("test back to back done");
	endtask
	task automatic t_nap;
		nap_n = 0;
		conv(14'h0F0F, n);
		tick(2);
		`CHK(nap, 1'b1)
		tick(4);
		`CHK(nap, 1'b1)
		// Long acquisition after nap
		cv_n = 1;
		tick(2);
		`CHK(nap, 1'b0)
		nap_n = 1;
		tick(4);
		cv_n = 0;
		tick(2);
		wbusy(n);
		$display("test nap done");
	endtask
	task automatic t_reset;
		core = 14'h1111;
		cs_n = 0;
		cv_n = 1;
		tick(2);
		cv_n = 0;
		tick(3);
		pr_n = 0;
		tick(2);
		`CHK(busy, 1'b0)
		rd(0, v);
		`CHK(v, sac_pkg::MARKER_CODE)
		tick(PH);
		`CHK(pd, 1'b1)
		pr_n = 1;
		tick(2);
		`CHK(pd, 1'b0)
		$display("test reset pin done");
	endtask
	task automatic t_fifo;
		// Park select high and convert low so no false edge follows reset
		cs_n = 1;
		cv_n = 0;
		rst = 1;
		tick(2);
		rst = 0;
		rdy = 0;
		tick(1);
		`CHK(busy, 1'b0)
		`CHK(smp, 1'b0)
		for (int i = 0; i < 10; i++) begin
			conv(14'h0100 + 14'(i), n);
			tick(1);
			if (i == 3) `CHK(rv, 1'b0)
			if (i == 4) `CHK(rv, 1'b1)
		end
		rdy = 1;
		n = 0;
		while (sv === 1'b1 && n < 12) begin
			`CHK(sd[13:0], 14'h0100 + 14'(n))
			tick(1);
			n++;
		end
		`CHK(n >= sac_pkg::FIFO_DEPTH, 1'b1)
		$display("test stream buffer done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			bad_count++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		tick(5);
		rst = 0;
		tick(1);
		t_basic();
		t_cs();
		t_abort();
		t_b2b();
		t_nap();
		t_reset();
		t_fifo();
		stop_test();
	end
endmodule
